// ==== design/vfd_dec_if.sv ====
`timescale 1ns/100ps
interface vfd_dec_if #(parameter int NPORTS = 7);
	logic              vlanEn;
	logic              vlanValid;
	logic              fwdOption;
	logic              dynQual;
	logic              staQual;
	logic              unkVidEn;
	logic              dropInvalid;
	logic              unkMcEn;
	logic              unkUcEn;
	logic              isBcast;
	logic              isMcast;
	logic              staUse;
	logic              dynUse;
	logic [NPORTS-1:0] members;
	logic [NPORTS-1:0] staPorts;
	logic [NPORTS-1:0] dynPorts;
	logic [NPORTS-1:0] unkVidPorts;
	logic [NPORTS-1:0] unkMcPorts;
	logic [NPORTS-1:0] unkUcPorts;
	logic [NPORTS-1:0] hostPorts;
	logic [NPORTS-1:0] fwdPorts;
	logic              discard;
	modport ctl (output vlanEn, vlanValid, fwdOption, dynQual, staQual, unkVidEn,
		dropInvalid, unkMcEn, unkUcEn, isBcast, isMcast, staUse, dynUse, members,
		staPorts, dynPorts, unkVidPorts, unkMcPorts, unkUcPorts, hostPorts,
		input fwdPorts, discard);
	modport sel (input vlanEn, vlanValid, fwdOption, dynQual, staQual, unkVidEn,
		dropInvalid, unkMcEn, unkUcEn, isBcast, isMcast, staUse, dynUse, members,
		staPorts, dynPorts, unkVidPorts, unkMcPorts, unkUcPorts, hostPorts,
		output fwdPorts, discard);
endinterface // vfd_dec_if

// ==== design/vfd_forward_top.sv ====
// Operation
// RULE_01 - hit needs matching group id
// RULE_02 - lookup miss floods VLAN members
// RULE_03 - filtering ANDs address and member lists
// RULE_04 - source miss learns address and group
// RULE_05 - untagged or null VID uses port default
// RULE_06 - VLAN lookup always; VID 1 all members
// RULE_07 - mode off: miss members, hit table
// RULE_08 - invalid VID: redirect, discard or host
// RULE_09 - miss routed by broadcast, multicast, unicast
// RULE_10 - filtering off: hit uses address list
// RULE_11 - forward option sends to members
// RULE_12 - VLAN enable is control0 bit 7
// RULE_13 - invalid discard is control0 bit 6
// RULE_14 - filtering bits control2 5,4 reset zero
// RULE_15 - software should set both filtering bits
// RULE_16 - static hit wins when group allows
// RULE_17 - else dynamic hit, else flood
// RULE_18 - source hit applies filter and priority
// RULE_19 - dynamic source hit refreshed, static untouched
// RULE_20 - one port bitmap per frame
`timescale 1ns/100ps
module vfd_forward_top #(
	parameter int NPORTS   = 7,
	parameter int VT_DEPTH = 16,
	parameter int PRIO_W   = 3
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// register bus
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output      logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output      logic                       s_axi_wready,
	output      logic [1:0]                 s_axi_bresp,
	output      logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [7:0]                 s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output      logic                       s_axi_arready,
	output      logic [31:0]                s_axi_rdata,
	output      logic [1:0]                 s_axi_rresp,
	output      logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// parsed frame from ingress
	input  wire logic                       frmValid,
	output      logic                       frmReady,
	input  wire logic [$clog2(NPORTS)-1:0]  frmPort,
	input  wire logic                       frmTagged,
	input  wire logic [vfd_pkg::VID_W-1:0]  frmVid,
	input  wire logic                       frmBcast,
	input  wire logic                       frmMcast,
	input  wire logic [vfd_pkg::HASH_W-1:0] frmDaHash,
	input  wire logic [vfd_pkg::HASH_W-1:0] frmSaHash,
	// address table lookup request
	output      logic                       lkReqValid,
	output      logic [vfd_pkg::HASH_W-1:0] lkDaHash,
	output      logic [vfd_pkg::HASH_W-1:0] lkSaHash,
	output      logic [vfd_pkg::FID_W-1:0]  lkFid,
	// address table lookup results
	input  wire logic                       lkRespValid,
	input  wire logic                       staHit,
	input  wire logic                       staGroupCheck,
	input  wire logic [vfd_pkg::FID_W-1:0]  staFid,
	input  wire logic [NPORTS-1:0]          staPorts,
	input  wire logic                       dynHit,
	input  wire logic [vfd_pkg::FID_W-1:0]  dynFid,
	input  wire logic [NPORTS-1:0]          dynPorts,
	input  wire logic                       saHit,
	input  wire logic [vfd_pkg::FID_W-1:0]  saFid,
	input  wire logic                       saStatic,
	input  wire logic                       saFilter,
	input  wire logic [PRIO_W-1:0]          saPrio,
	// egress decision
	output      logic                       fwdValid,
	output      logic [NPORTS-1:0]          fwdPorts,
	output      logic                       fwdDiscard,
	output      logic                       fwdSrcFilter,
	output      logic [PRIO_W-1:0]          fwdPrio,
	// learning and refresh
	output      logic                       learnValid,
	output      logic                       refreshValid,
	output      logic [NPORTS-1:0]          refreshPorts
);
	import vfd_pkg::*;
	localparam int SLOT_W = $clog2(VT_DEPTH);
	localparam int PORT_W = $clog2(NPORTS);

	// control registers
	logic                     vlanEn_q;
	logic                     drop_q;
	logic                     dynQual_q;
	logic                     staQual_q;
	logic [31:0]              unkVid_q;
	logic [31:0]              unkMc_q;
	logic [31:0]              unkUc_q;
	logic [PORT_W-1:0]        hostPort_q;
	logic [VID_W-1:0]         vtIndex_q;
	logic [VID_W-1:0]         pvid_q [NPORTS];
	logic [15:0]              frameCnt_q;
	// vlan table storage
	logic                     vtValid_q [VT_DEPTH];
	logic                     vtOpt_q   [VT_DEPTH];
	logic [VID_W-1:0]         vtTag_q   [VT_DEPTH];
	logic [FID_W-1:0]         vtFid_q   [VT_DEPTH];
	logic [NPORTS-1:0]        vtMemb_q  [VT_DEPTH];
	// bus state
	logic                     awHave_q;
	logic                     wHave_q;
	logic [7:0]               awAddr_q;
	logic [31:0]              wData_q;
	logic [3:0]               wStrb_q;
	logic                     wrGo;
	logic [31:0]              wMask;
	// frame pipeline
	vfd_state_t               state_q;
	logic [VID_W-1:0]         effVid_q;
	logic                     bcast_q;
	logic                     mcast_q;
	logic [PORT_W-1:0]        port_q;
	logic                     vValid_q;
	logic                     vOpt_q;
	logic [NPORTS-1:0]        memb_q;
	logic [SLOT_W-1:0]        slot;
	logic                     resp;

	vfd_dec_if #(.NPORTS(NPORTS)) dec ();

	vfd_port_select u_sel (
		.d (dec)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
		merge = (old & ~m) | (wData_q & m);
	endfunction

	// ---------------- register bus ----------------
	assign s_axi_awready = !awHave_q && !s_axi_bvalid;
	assign s_axi_wready  = !wHave_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrGo          = awHave_q && wHave_q;
	assign wMask         = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= ADDR_STATUS && a[1:0] == 2'b00) ||
			(a >= ADDR_PVID_BASE && a < ADDR_PVID_BASE + 8'(NPORTS * 4) && a[1:0] == 2'b00);
	endfunction

	always_ff @(posedge clk) begin
		if (!resetn) begin
			awHave_q     <= 1'b0;
			wHave_q      <= 1'b0;
			awAddr_q     <= 8'h00;
			wData_q      <= 32'h0;
			wStrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrGo) begin
				awHave_q     <= 1'b0;
				wHave_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] rdMux(input logic [7:0] a);
		logic [SLOT_W-1:0] s;
		s = vtIndex_q[SLOT_W-1:0];
		rdMux = 32'h0;
		case (a)
			ADDR_LUE_CTRL0: begin
				rdMux[CTRL0_VLAN_EN_BIT] = vlanEn_q;
				rdMux[CTRL0_DROP_BIT] = drop_q;
			end
			ADDR_LUE_CTRL2: begin
				rdMux[CTRL2_DYN_QUAL] = dynQual_q;
				rdMux[CTRL2_STA_QUAL] = staQual_q;
			end
			ADDR_UNK_VID: rdMux = unkVid_q;
			ADDR_UNK_MC: rdMux = unkMc_q;
			ADDR_UNK_UC: rdMux = unkUc_q;
			ADDR_HOST_PORT: rdMux[PORT_W-1:0] = hostPort_q;
			ADDR_VT_INDEX: rdMux[VID_W-1:0] = vtIndex_q;
			ADDR_VT_ENTRY: begin
				if (vtTag_q[s] == vtIndex_q) begin
					rdMux[VT_VALID_BIT] = vtValid_q[s];
					rdMux[VT_FWDOPT_BIT] = vtOpt_q[s];
					rdMux[VT_FID_LSB +: FID_W] = vtFid_q[s];
					rdMux[NPORTS-1:0] = vtMemb_q[s];
				end
			end
			ADDR_STATUS: rdMux[15:0] = frameCnt_q;
			default: begin
				for (int p = 0; p < NPORTS; p++) begin
					if (a == ADDR_PVID_BASE + 8'(p * 4)) begin
						rdMux[VID_W-1:0] = pvid_q[p];
					end
				end
			end
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= mapped(s_axi_araddr) ? rdMux(s_axi_araddr) : 32'h0;
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------- control registers ----------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			vlanEn_q   <= 1'b0;
			drop_q     <= DROP_RESET;
			dynQual_q  <= 1'b0;
			staQual_q  <= 1'b0;
			unkVid_q   <= 32'h0;
			unkMc_q    <= 32'h0;
			unkUc_q    <= 32'h0;
			hostPort_q <= '0;
			vtIndex_q  <= VID_DEFAULT;
		end else if (wrGo) begin
			case (awAddr_q)
				ADDR_LUE_CTRL0: if (wStrb_q[0]) begin
					// RULE_12 enable bit
					vlanEn_q <= wData_q[CTRL0_VLAN_EN_BIT];
					// RULE_13 discard bit
					drop_q <= wData_q[CTRL0_DROP_BIT];
				end
				ADDR_LUE_CTRL2: if (wStrb_q[0]) begin
					// RULE_14 filtering bits
					dynQual_q <= wData_q[CTRL2_DYN_QUAL];
					staQual_q <= wData_q[CTRL2_STA_QUAL];
				end
				ADDR_UNK_VID: unkVid_q <= merge(unkVid_q, wMask);
				ADDR_UNK_MC: unkMc_q <= merge(unkMc_q, wMask);
				ADDR_UNK_UC: unkUc_q <= merge(unkUc_q, wMask);
				ADDR_HOST_PORT: hostPort_q <= wData_q[PORT_W-1:0];
				ADDR_VT_INDEX: vtIndex_q <= wData_q[VID_W-1:0];
				default: ;
			endcase
		end
	end

	// RULE_05 default VID per port
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int p = 0; p < NPORTS; p++) pvid_q[p] <= VID_DEFAULT;
		end else if (wrGo) begin
			for (int p = 0; p < NPORTS; p++) begin
				if (awAddr_q == ADDR_PVID_BASE + 8'(p * 4)) pvid_q[p] <= wData_q[VID_W-1:0];
			end
		end
	end

	// RULE_06 VID 1 all members
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < VT_DEPTH; i++) begin
				vtValid_q[i] <= (i == int'(VID_DEFAULT));
				vtOpt_q[i]   <= 1'b0;
				vtTag_q[i]   <= VID_DEFAULT;
				vtFid_q[i]   <= '0;
				vtMemb_q[i]  <= '1;
			end
		end else if (wrGo && awAddr_q == ADDR_VT_ENTRY) begin
			vtValid_q[vtIndex_q[SLOT_W-1:0]] <= wData_q[VT_VALID_BIT];
			vtOpt_q[vtIndex_q[SLOT_W-1:0]]   <= wData_q[VT_FWDOPT_BIT];
			vtTag_q[vtIndex_q[SLOT_W-1:0]]   <= vtIndex_q;
			vtFid_q[vtIndex_q[SLOT_W-1:0]]   <= wData_q[VT_FID_LSB +: FID_W];
			vtMemb_q[vtIndex_q[SLOT_W-1:0]]  <= wData_q[NPORTS-1:0];
		end
	end

	// ---------------- frame pipeline ----------------
	assign frmReady   = (state_q == ST_IDLE);
	assign lkReqValid = (state_q == ST_LOOK);
	assign resp       = (state_q == ST_LOOK) && lkRespValid;
	assign slot       = effVid_q[SLOT_W-1:0];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: if (frmValid) state_q <= ST_VLAN;
				ST_VLAN: state_q <= ST_LOOK;
				ST_LOOK: if (lkRespValid) state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			effVid_q <= VID_DEFAULT;
			bcast_q  <= 1'b0;
			mcast_q  <= 1'b0;
			port_q   <= '0;
			lkDaHash <= '0;
			lkSaHash <= '0;
		end else if (frmValid && frmReady) begin
			// RULE_05 default VID substitution
			effVid_q <= (!vlanEn_q || !frmTagged || frmVid == VID_NULL) ? pvid_q[frmPort] : frmVid;
			bcast_q  <= frmBcast;
			mcast_q  <= frmMcast;
			port_q   <= frmPort;
			lkDaHash <= frmDaHash;
			lkSaHash <= frmSaHash;
		end
	end

	// RULE_06 table read in every mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			vValid_q <= 1'b0;
			vOpt_q   <= 1'b0;
			memb_q   <= '0;
			lkFid    <= '0;
		end else if (state_q == ST_VLAN) begin
			vValid_q <= vtValid_q[slot] && vtTag_q[slot] == effVid_q;
			vOpt_q   <= vtOpt_q[slot];
			memb_q   <= vtMemb_q[slot];
			lkFid    <= vtFid_q[slot];
		end
	end

	assign dec.vlanEn      = vlanEn_q;
	assign dec.vlanValid   = vValid_q;
	assign dec.fwdOption   = vOpt_q;
	assign dec.dynQual     = dynQual_q;
	assign dec.staQual     = staQual_q;
	assign dec.unkVidEn    = unkVid_q[UNK_EN_BIT];
	assign dec.dropInvalid = drop_q;
	assign dec.unkMcEn     = unkMc_q[UNK_EN_BIT];
	assign dec.unkUcEn     = unkUc_q[UNK_EN_BIT];
	assign dec.isBcast     = bcast_q;
	assign dec.isMcast     = mcast_q;
	// RULE_16 group check on static
	assign dec.staUse      = staHit && (!staGroupCheck || staFid == lkFid);
	// RULE_01 group must match
	assign dec.dynUse      = dynHit && dynFid == lkFid;
	assign dec.members     = memb_q;
	assign dec.staPorts    = staPorts;
	assign dec.dynPorts    = dynPorts;
	assign dec.unkVidPorts = unkVid_q[NPORTS-1:0];
	assign dec.unkMcPorts  = unkMc_q[NPORTS-1:0];
	assign dec.unkUcPorts  = unkUc_q[NPORTS-1:0];
	assign dec.hostPorts   = NPORTS'(1) << hostPort_q;

	logic saMatch;
	logic learnOk;
	assign saMatch = saHit && saFid == lkFid;
	assign learnOk = !vlanEn_q || vValid_q;

	// RULE_20 one bitmap per frame
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fwdValid     <= 1'b0;
			fwdPorts     <= '0;
			fwdDiscard   <= 1'b0;
			fwdSrcFilter <= 1'b0;
			fwdPrio      <= '0;
			frameCnt_q   <= 16'h0;
		end else begin
			fwdValid <= resp;
			if (resp) begin
				fwdPorts   <= dec.fwdPorts;
				fwdDiscard <= dec.discard;
				// RULE_18 source hit attributes
				fwdSrcFilter <= saMatch && saFilter;
				fwdPrio      <= saMatch ? saPrio : '0;
				frameCnt_q   <= frameCnt_q + 16'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			learnValid   <= 1'b0;
			refreshValid <= 1'b0;
			refreshPorts <= '0;
		end else begin
			// RULE_04 learn on miss
			learnValid   <= resp && learnOk && !saMatch;
			// RULE_19 refresh dynamic only
			refreshValid <= resp && learnOk && saMatch && !saStatic;
			if (resp) refreshPorts <= NPORTS'(1) << port_q;
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_miss_flood;
		resp && vlanEn_q && vValid_q && !dec.staUse && !dec.dynUse && bcast_q
			|=> fwdValid && fwdPorts == $past(memb_q);
	endproperty
	a_miss_flood: assert property (p_miss_flood) else $error("miss not flooded"); // RULE_02

	property p_invalid_drop;
		resp && vlanEn_q && !vValid_q && !unkVid_q[UNK_EN_BIT] && drop_q
			|=> fwdDiscard && fwdPorts == '0 && !learnValid;
	endproperty
	a_invalid_drop: assert property (p_invalid_drop) else $error("invalid VID kept"); // RULE_08

	property p_opt_members;
		resp && vlanEn_q && vValid_q && vOpt_q && dec.dynUse |=> fwdPorts == $past(memb_q);
	endproperty
	a_opt_members: assert property (p_opt_members) else $error("option ignored"); // RULE_11

	property p_learn;
		resp && !vlanEn_q && !saHit |=> learnValid && !refreshValid;
	endproperty
	a_learn: assert property (p_learn) else $error("no learn on miss"); // RULE_04

	property p_static_sa;
		resp && saHit && saFid == lkFid && saStatic |=> !refreshValid && !learnValid;
	endproperty
	a_static_sa: assert property (p_static_sa) else $error("static entry touched"); // RULE_19

	property p_once;
		fwdValid |=> !fwdValid;
	endproperty
	a_once: assert property (p_once) else $error("double result"); // RULE_20

	property p_untagged;
		frmValid && frmReady && !frmTagged |=> effVid_q == $past(pvid_q[frmPort]);
	endproperty
	a_untagged: assert property (p_untagged) else $error("default VID unused"); // RULE_05

	property p_fid_mismatch;
		resp && !vlanEn_q && !staHit && dynHit && dynFid != lkFid
			|=> fwdPorts == $past(memb_q);
	endproperty
	a_fid_mismatch: assert property (p_fid_mismatch) else $error("group mismatch hit"); // RULE_01

	property p_filter_and;
		resp && vlanEn_q && vValid_q && !vOpt_q && !dec.staUse && dec.dynUse && dynQual_q
			|=> fwdPorts == ($past(dynPorts) & $past(memb_q));
	endproperty
	a_filter_and: assert property (p_filter_and) else $error("no member AND"); // RULE_03

	property p_latency;
		frmValid && frmReady |=> ##1 lkReqValid;
	endproperty
	a_latency: assert property (p_latency) else $error("request late");

	c_discard: cover property (resp && dec.discard);
	c_static: cover property (resp && dec.staUse && vlanEn_q);
	c_learn: cover property (learnValid ##1 frmValid);
endmodule // vfd_forward_top

// ==== design/vfd_pkg.sv ====
package vfd_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_LUE_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_LUE_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_UNK_VID   = 8'h08;
	localparam logic [7:0] ADDR_UNK_MC    = 8'h0c;
	localparam logic [7:0] ADDR_UNK_UC    = 8'h10;
	localparam logic [7:0] ADDR_HOST_PORT = 8'h14;
	localparam logic [7:0] ADDR_VT_INDEX  = 8'h18;
	localparam logic [7:0] ADDR_VT_ENTRY  = 8'h1c;
	localparam logic [7:0] ADDR_STATUS    = 8'h20;
	localparam logic [7:0] ADDR_PVID_BASE = 8'h40;
	localparam logic [7:0] ADDR_STRIDE    = 8'h04;
	// field positions
	localparam int CTRL0_VLAN_EN_BIT = 7;
	localparam int CTRL0_DROP_BIT    = 6;
	localparam int CTRL2_DYN_QUAL    = 5;
	localparam int CTRL2_STA_QUAL    = 4;
	localparam int UNK_EN_BIT        = 31;
	localparam int VT_VALID_BIT      = 31;
	localparam int VT_FWDOPT_BIT     = 30;
	localparam int VT_FID_LSB        = 16;
	// widths and reset values
	localparam int VID_W  = 12;
	localparam int FID_W  = 7;
	localparam int HASH_W = 10;
	localparam logic [VID_W-1:0] VID_NULL    = 12'h000;
	localparam logic [VID_W-1:0] VID_DEFAULT = 12'h001;
	localparam logic             DROP_RESET  = 1'b1;
	localparam logic [1:0]       RESP_OKAY   = 2'b00;
	localparam logic [1:0]       RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_VLAN = 3'b010,
		ST_LOOK = 3'b100
	} vfd_state_t;
endpackage

// ==== design/vfd_port_select.sv ====
`timescale 1ns/100ps
module vfd_port_select (
	vfd_dec_if.sel d
);
	import vfd_pkg::*;
	logic addrHit;
	assign addrHit = d.staUse | d.dynUse;
	always_comb begin
		d.discard = 1'b0;
		// RULE_16 static wins
		// RULE_17 dynamic or flood
		if (!d.vlanEn) begin
			// RULE_07 mode off
			d.fwdPorts = d.staUse ? d.staPorts : (d.dynUse ? d.dynPorts : d.members);
		end else if (!d.vlanValid) begin
			// RULE_08 invalid entry
			if (d.unkVidEn) begin
				d.fwdPorts = d.unkVidPorts;
			end else if (d.dropInvalid) begin
				d.fwdPorts = '0;
				d.discard = 1'b1;
			end else begin
				d.fwdPorts = d.hostPorts;
			end
		end else if (!addrHit) begin
			// RULE_02 miss floods members
			// RULE_09 miss by type
			if (d.isBcast) begin
				d.fwdPorts = d.members;
			end else if (d.isMcast) begin
				d.fwdPorts = d.unkMcEn ? d.unkMcPorts : d.members;
			end else begin
				d.fwdPorts = d.unkUcEn ? d.unkUcPorts : d.members;
			end
		end else if (d.fwdOption) begin
			// RULE_11 option overrides
			d.fwdPorts = d.members;
		end else if (d.staUse) begin
			// RULE_03 membership AND
			d.fwdPorts = d.staQual ? (d.staPorts & d.members) : d.staPorts;
		end else begin
			// RULE_10 unfiltered hit
			d.fwdPorts = d.dynQual ? (d.dynPorts & d.members) : d.dynPorts;
		end
	end
endmodule // vfd_port_select

// ==== verification/vfd_lookup_model.sv ====
`timescale 1ns/100ps
module vfd_lookup_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// lookup handshake
	input  wire logic       lkReqValid,
	input  wire logic [1:0] delay,
	output      logic       lkRespValid
);
	logic [1:0] waitCnt_q;
	// slow or prompt answer
	always_ff @(posedge clk) begin
		if (!resetn || !lkReqValid || lkRespValid)
			waitCnt_q <= 2'h0;
		else
			waitCnt_q <= waitCnt_q + 2'h1;
	end
	assign lkRespValid = lkReqValid && waitCnt_q == delay;
endmodule // vfd_lookup_model

// ==== verification/vlan_forwarding_decision_bench.sv ====
`timescale 1ns/100ps
module vlan_forwarding_decision_bench;
	import vfd_pkg::*;
	logic clk = 0, resetn = 0, frmValid = 0, frmTagged = 0, frmBcast = 0, frmMcast = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, staHit = 0, staGroupCheck = 0, dynHit = 0, saHit = 0;
	logic saStatic = 0, saFilter = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, frmReady, lkReqValid, lkRespValid, fwdValid;
	logic fwdDiscard, fwdSrcFilter, learnValid, refreshValid, cx, cl, cq, cs, fo, vl, fx;
	logic vEn = 0, drop = 1, dq = 0, sq = 0, uvEn = 0, umEn = 0, uuEn = 0, pv2 = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, cb, cr, dly = 0;
	logic [2:0] frmPort = 0, saPrio = 0, fwdPrio, cpr;
	logic [6:0] staFid = 0, dynFid = 0, saFid = 0, staPorts = 0, dynPorts = 0;
	logic [6:0] lkFid, fwdPorts, refreshPorts, cf, cp, crp, mem5, fid5, uv, um, uu, hp, mv, fv;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [9:0] frmDaHash = 0, frmSaHash = 0, lkDaHash, lkSaHash;
	logic [19:0] ch;
	logic [11:0] frmVid = 0, vids [4] = '{12'h0, 12'h1, 12'h5, 12'h15};
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, cd;
	int num_errors = 0, checked = 0;
	wire logic [5:0] rv = {fwdValid, lkReqValid, frmReady, s_axi_rvalid, s_axi_arready,
		s_axi_bvalid};
	vfd_forward_top i_vfd_forward_top (.s_axi_wstrb(4'hf), .*);
	vfd_lookup_model i_vfd_lookup_model (.clk, .resetn, .lkReqValid, .delay(dly), .lkRespValid);
	always #2.5 clk = ~clk;
	// outputs as they stand before each edge
	always @(negedge clk)
		{cb, cr, cd, cf, cp, cx, cl, cq, cs, crp, cpr, ch} <= {s_axi_bresp, s_axi_rresp,
			s_axi_rdata, lkFid, fwdPorts, fwdDiscard, learnValid, refreshValid, fwdSrcFilter,
			refreshPorts, fwdPrio, lkDaHash, lkSaHash};
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wt(input int s);
		for (int n = 0; n < 99; n++) begin
			@(negedge clk);
			if (rv[s] === 1'b1) begin
				@(posedge clk);
				return;
			end
		end
		num_errors++;
		close_out();
	endtask
	task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ga, gw;
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
		{ga, gw} = 2'b00;
		for (int n = 0; n < 99 && !(ga && gw); n++) begin
			@(negedge clk);
			ga |= s_axi_awready;
			gw |= s_axi_wready;
			@(posedge clk);
			{s_axi_awvalid, s_axi_wvalid} <= {!ga, !gw};
		end
		s_axi_bready <= 1;
		wt(0);
		s_axi_bready <= 0;
		ck(32'(cb), 32'(r));
	endtask
	task automatic ar(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		{s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
		wt(1);
		{s_axi_arvalid, s_axi_rready} <= 2'b01;
		wt(2);
		s_axi_rready <= 0;
		ck(cd, d);
		ck(32'(cr), 32'(r));
	endtask
	function automatic logic [7:0] ex();
		logic so, h;
		logic [6:0] l;
		so = staHit && (!staGroupCheck || staFid == fv);
		h = so || dynHit && dynFid == fv;
		l = so ? staPorts : dynPorts;
		if (vEn && !vl)
			return uvEn ? {1'b0, uv} : drop ? 8'h80 : {1'b0, 7'h1 << hp[2:0]};
		if (!h)
			return {1'b0, !vEn || frmBcast ? mv : frmMcast ? (umEn ? um : mv) : (uuEn ? uu : mv)};
		return {1'b0, vEn && fx ? mv : vEn && (so ? sq : dq) ? l & mv : l};
	endfunction
	task automatic cfg();
		{vEn, drop, dq, sq, uvEn, umEn, uuEn, fo} = 8'($urandom);
		{mem5, fid5, uv, um, uu, hp} = 42'({$urandom, $urandom});
		hp = 7'($urandom % 7);
		aw(ADDR_LUE_CTRL0, {24'h0, vEn, drop, 6'h0}, 2'h0);
		aw(ADDR_LUE_CTRL2, {26'h0, dq, sq, 4'h0}, 2'h0);
		aw(ADDR_UNK_VID, {uvEn, 24'h0, uv}, 2'h0);
		aw(ADDR_UNK_MC, {umEn, 24'h0, um}, 2'h0);
		aw(ADDR_UNK_UC, {uuEn, 24'h0, uu}, 2'h0);
		aw(ADDR_HOST_PORT, {25'h0, hp}, 2'h0);
		aw(ADDR_VT_ENTRY, {1'b1, fo, 7'h0, fid5, 9'h0, mem5}, 2'h0);
	endtask
	task automatic fr();
		logic [11:0] v0, v;
		logic [2:0] p;
		logic [1:0] t;
		logic tg, sa, k, rf;
		{p, t, tg} = {3'($urandom % 7), 2'($urandom % 3), 1'($urandom)};
		v0 = vids[$urandom % 4];
		v = (!vEn || !tg || v0 == 12'h0) ? (p == 3'h2 && pv2 ? 12'h5 : 12'h1) : v0;
		{vl, fx} = {v == 12'h1 || v == 12'h5, v == 12'h5 && fo};
		// slot 5 also serves the aliasing invalid VID
		{fv, mv} = v[3:0] == 4'h5 ? {fid5, mem5} : {7'h0, 7'h7f};
		{frmPort, frmTagged, frmVid, frmBcast, frmMcast} <= {p, tg, v0, t == 2'h1, t == 2'h2};
		{frmDaHash, frmSaHash, saPrio, dly} <= 25'($urandom);
		{staHit, staGroupCheck, dynHit, saHit, saStatic, saFilter} <= 6'($urandom);
		{staPorts, dynPorts} <= 14'($urandom);
		staFid <= $urandom % 2 ? fv : 7'($urandom);
		dynFid <= $urandom % 2 ? fv : 7'($urandom);
		saFid <= $urandom % 2 ? fv : 7'($urandom);
		frmValid <= 1;
		wt(3);
		frmValid <= 0;
		wt(4);
		if (vl)
			ck(32'(cf), 32'(fv));
		ck(32'(ch), 32'({frmDaHash, frmSaHash}));
		wt(5);
		sa = saHit && saFid == fv;
		k = !vEn || vl;
		rf = k && sa && !saStatic;
		ck(32'({cx, cx ? 7'h0 : cp}), 32'(ex()));
		ck(32'({cl, cq & k, cs & k, cq & k ? crp : 7'h0}),
			32'({k && !sa, rf, k && sa && saFilter, rf ? 7'(1 << p) : 7'h0}));
		ck(32'(cpr), 32'(sa ? saPrio : 3'h0));
	endtask
	initial begin
		void'($urandom(58));
		repeat (12) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		ar(ADDR_LUE_CTRL0, 32'h40, 2'h0);
		ar(ADDR_LUE_CTRL2, 32'h0, 2'h0);
		ar(ADDR_PVID_BASE, 32'h1, 2'h0);
		ar(ADDR_VT_ENTRY, 32'h8000007f, 2'h0);
		ar(8'h32, 32'h0, 2'h2);
		aw(8'h30, 32'h1, 2'h2);
		repeat (30) fr();
		aw(ADDR_PVID_BASE + 8'h08, 32'h5, 2'h0);
		aw(ADDR_VT_INDEX, 32'h5, 2'h0);
		pv2 = 1;
		repeat (25) begin
			cfg();
			repeat (20) fr();
		end
		ar(ADDR_STATUS, 32'h212, 2'h0);
		close_out();
	end
endmodule // vlan_forwarding_decision_bench
